// *** pkg/eeprom_pkg.sv ***
package eeprom_pkg;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W     = 10;
  localparam int unsigned DEPTH      = 1024;
  localparam int unsigned PAGE_W     = 5;
  localparam int unsigned PAGE_BYTES = 32;

  // ----------------------------------------------------------------
  // Instruction codes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_LATCH_SET   = 8'h06;
  localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
  localparam logic [7:0] OP_SR_READ     = 8'h05;
  localparam logic [7:0] OP_SR_WRITE    = 8'h01;
  localparam logic [7:0] OP_ARRAY_READ  = 8'h03;
  localparam logic [7:0] OP_ARRAY_WRITE = 8'h02;

  // ----------------------------------------------------------------
  // Status register layout and reset values
  // ----------------------------------------------------------------
  localparam int unsigned SR_GATE_POS   = 7;
  localparam int unsigned SR_BG_HI_POS  = 3;
  localparam int unsigned SR_BG_LO_POS  = 2;
  localparam logic        GATE_RESET    = 1'b0;
  localparam logic [1:0]  BG_RESET      = 2'b00;
  localparam logic [4:0]  PIN_IDLE      = 5'h1A;
  localparam logic [7:0]  SR_BUSY_VALUE = 8'hFF;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ     = 200;
  localparam int unsigned T_WC_US     = 5000;
  localparam int unsigned WC_CYCLES   = T_WC_US * CLK_MHZ;
  localparam int unsigned WC_CNT_W    = 20;

  // ----------------------------------------------------------------
  // Block guard decode
  // ----------------------------------------------------------------
  function automatic logic guarded(input logic [1:0] bg, input logic [ADDR_W-1:0] a);
    case (bg)
      2'b01:   return (a[9:8] == 2'b11);
      2'b10:   return a[9];
      2'b11:   return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

endpackage

// *** pkg/array_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface array_if;
  import eeprom_pkg::*;
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0]        wr_data;
  logic [ADDR_W-1:0] rd_addr;
  logic [7:0]        rd_data;

  modport ctrl  (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
  modport store (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface

`default_nettype wire

// *** rtl/pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int unsigned  W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_nrst,
  // Pins
  input  wire logic [W-1:0] i_pin,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_r;

  // ----------------------------------------------------------------
  // Two flip-flop synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_r <= RST_VAL;
      o_sync <= RST_VAL;
    end else begin
      meta_r <= i_pin;
      o_sync <= meta_r;
    end
  end

endmodule // pin_sync

`default_nettype wire

// *** rtl/cell_array.sv ***
`timescale 1ns/1ps
`default_nettype none

module cell_array
  import eeprom_pkg::*;
(
  // Clock
  input  wire logic i_clk,
  // Array port
  array_if.store    mem
);

  logic [7:0] cell_r [DEPTH];

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (mem.wr_en) begin
      cell_r[mem.wr_addr] <= mem.wr_data;
    end
  end

  assign mem.rd_data = cell_r[mem.rd_addr];

endmodule // cell_array

`default_nettype wire

// *** rtl/spi_eeprom.sv ***
// How it works
// - Guard bits pick none, quarter, half, all
// - Writes into guarded region are dropped
// - No array or status write without latch
// - Gate bit plus low pin blocks status write
// - With gate bit set, pin low before select rise aborts status write
// - Reset leaves latch cleared, idle standby
// - Latch sets on select rise after set command
// - Clear command clears the write latch
// - Sixteen address bits, low ten kept
// - Programming starts at select rise, whole bytes
// - Only status read accepted while busy
// - Busy flag high during internal write
// - Up to 32 bytes, low bits increment
// - Page loading wraps within the page
// - Latch clears when write cycle ends
// - Status write changes bits 2, 3, 7
// - Read streams bytes with address increment
// - Read address wraps top to zero
// - Status read shifts status; FFh when busy
// - Hold floats output, ignores input
// - Unknown code ignored, output stays floating
// - Eight-bit instruction codes as listed
// - Sample on rising, drive on falling edge
// - Status bit layout gate, guards, latch, busy
// - Internal write cycle lasts five milliseconds
`timescale 1ns/1ps
`default_nettype none

module spi_eeprom
  import eeprom_pkg::*;
#(
  parameter int unsigned P_WC_CYCLES = WC_CYCLES
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_nrst,
  // Serial link pins
  input  wire logic i_sck,
  input  wire logic i_cs_n,
  input  wire logic i_si,
  input  wire logic i_hold_n,
  input  wire logic i_wp_n,
  output logic      o_so,
  output logic      o_so_oe,
  // Status
  output logic      o_busy
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_CMD, ST_ADDR, ST_WDATA, ST_RDATA, ST_SRDATA, ST_SRW, ST_IGNORE
  } state_e;

  // ----------------------------------------------------------------
  // Pin synchronisation and edge detection
  // ----------------------------------------------------------------
  logic [4:0] pins_s;
  logic       s_sck;
  logic       s_cs_n;
  logic       s_si;
  logic       s_hold_n;
  logic       s_wp_n;
  logic       sck_d_r;
  logic       cs_d_r;

  pin_sync #(.W(5), .RST_VAL(PIN_IDLE)) u_sync (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_pin  ({i_wp_n, i_hold_n, i_si, i_cs_n, i_sck}),
    .o_sync (pins_s)
  );

  assign s_sck    = pins_s[0];
  assign s_cs_n   = pins_s[1];
  assign s_si     = pins_s[2];
  assign s_hold_n = pins_s[3];
  assign s_wp_n   = pins_s[4];

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sck_d_r <= 1'b0;
      cs_d_r  <= 1'b1;
    end else begin
      sck_d_r <= s_sck;
      cs_d_r  <= s_cs_n;
    end
  end

  // ----------------------------------------------------------------
  // Shared state
  // ----------------------------------------------------------------
  state_e            st_r;
  logic [3:0]        bit_cnt_r;
  logic [15:0]       in_sr_r;
  logic              is_wr_r;
  logic [ADDR_W-1:0] addr_r;
  logic [2:0]        out_cnt_r;
  logic [7:0]        out_sr_r;
  logic              wel_r;
  logic              set_pend_r;
  logic              gate_r;
  logic [1:0]        bg_r;
  logic              busy_r;
  logic [WC_CNT_W-1:0] wc_cnt_r;
  logic [PAGE_W:0]   cm_idx_r;
  logic [7:0]        page_r [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] vld_r;
  logic [7:0]        sr_new_r;
  logic              sr_got_r;
  logic              sr_ok_r;

  array_if arr ();

  cell_array u_array (
    .i_clk (i_clk),
    .mem   (arr)
  );

  // ----------------------------------------------------------------
  // Event decode
  // ----------------------------------------------------------------
  logic       sck_rise;
  logic       sck_fall;
  logic       cs_rise;
  logic [7:0] rx_byte;
  logic       byte_end;
  logic       cmd_end;
  logic       addr_end;
  logic       wbyte_end;
  logic       rd_byte_done;
  logic       wp_block;
  logic       wr_go;
  logic       sr_go;
  logic       cycle_end;
  logic [7:0] sr_val;

  always_comb begin
    sck_rise     = s_sck & ~sck_d_r & ~s_cs_n & s_hold_n;
    sck_fall     = ~s_sck & sck_d_r & ~s_cs_n & s_hold_n;
    cs_rise      = s_cs_n & ~cs_d_r;
    rx_byte      = {in_sr_r[6:0], s_si};
    byte_end     = sck_rise && (bit_cnt_r[2:0] == 3'd7);
    cmd_end      = byte_end && (st_r == ST_CMD);
    addr_end     = sck_rise && (st_r == ST_ADDR) && (bit_cnt_r == 4'd15);
    wbyte_end    = byte_end && (st_r == ST_WDATA);
    rd_byte_done = sck_fall && (st_r == ST_RDATA) && (out_cnt_r == 3'd7);
    wp_block     = gate_r & ~s_wp_n;
    wr_go        = cs_rise && (st_r == ST_WDATA) && (bit_cnt_r == 4'd0)
                   && (|vld_r) && wel_r;
    sr_go        = cs_rise && (st_r == ST_SRW) && (bit_cnt_r == 4'd0)
                   && sr_got_r && sr_ok_r && wel_r && !wp_block;
    cycle_end    = busy_r && (wc_cnt_r == WC_CNT_W'(P_WC_CYCLES - 1));
    sr_val       = busy_r ? SR_BUSY_VALUE
                          : {gate_r, 3'b000, bg_r, wel_r, busy_r};
  end

  // ----------------------------------------------------------------
  // Session state machine
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r      <= ST_IDLE;
      bit_cnt_r <= 4'd0;
      in_sr_r   <= 16'h0000;
      is_wr_r   <= 1'b0;
    end else if (s_cs_n) begin
      st_r      <= ST_IDLE;
      bit_cnt_r <= 4'd0;
    end else if (st_r == ST_IDLE) begin
      st_r      <= ST_CMD;
      bit_cnt_r <= 4'd0;
    end else if (sck_rise) begin
      in_sr_r   <= {in_sr_r[14:0], s_si};
      bit_cnt_r <= (st_r == ST_ADDR) ? bit_cnt_r + 4'd1 : {1'b0, bit_cnt_r[2:0] + 3'd1};
      case (st_r)
        ST_CMD: begin
          if (bit_cnt_r == 4'd7) begin
            bit_cnt_r <= 4'd0;
            if (busy_r && rx_byte != OP_SR_READ) begin
              st_r <= ST_IGNORE;
            end else begin
              case (rx_byte)
                OP_SR_READ:     st_r <= ST_SRDATA;
                OP_SR_WRITE:    st_r <= wel_r ? ST_SRW : ST_IGNORE;
                OP_ARRAY_READ: begin
                  st_r    <= ST_ADDR;
                  is_wr_r <= 1'b0;
                end
                OP_ARRAY_WRITE: begin
                  st_r    <= wel_r ? ST_ADDR : ST_IGNORE;
                  is_wr_r <= 1'b1;
                end
                default:        st_r <= ST_IGNORE;
              endcase
            end
          end
        end
        ST_ADDR: begin
          if (bit_cnt_r == 4'd15) begin
            st_r      <= is_wr_r ? ST_WDATA : ST_RDATA;
            bit_cnt_r <= 4'd0;
          end
        end
        ST_WDATA, ST_SRW, ST_RDATA, ST_SRDATA, ST_IGNORE: begin
        end
        default: st_r <= ST_IGNORE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Address pointer
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      addr_r <= '0;
    end else if (addr_end) begin
      addr_r <= {in_sr_r[8:0], s_si};
    end else if (wbyte_end) begin
      addr_r[PAGE_W-1:0] <= addr_r[PAGE_W-1:0] + PAGE_W'(1);
    end else if (rd_byte_done) begin
      addr_r <= addr_r + ADDR_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Serial output
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_so      <= 1'b0;
      o_so_oe   <= 1'b0;
      out_cnt_r <= 3'd0;
      out_sr_r  <= 8'h00;
    end else begin
      o_so_oe <= ~s_cs_n & s_hold_n
                 & ((st_r == ST_RDATA) || (st_r == ST_SRDATA));
      if (st_r != ST_RDATA && st_r != ST_SRDATA) begin
        out_cnt_r <= 3'd0;
      end else if (sck_fall) begin
        out_cnt_r <= out_cnt_r + 3'd1;
        if (out_cnt_r == 3'd0) begin
          o_so     <= (st_r == ST_RDATA) ? arr.rd_data[7] : sr_val[7];
          out_sr_r <= (st_r == ST_RDATA) ? {arr.rd_data[6:0], 1'b0}
                                         : {sr_val[6:0], 1'b0};
        end else begin
          o_so     <= out_sr_r[7];
          out_sr_r <= {out_sr_r[6:0], 1'b0};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Write latch
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      set_pend_r <= 1'b0;
    end else if (cmd_end) begin
      set_pend_r <= (rx_byte == OP_LATCH_SET) && !busy_r;
    end else if (sck_rise || cs_rise) begin
      set_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wel_r <= 1'b0;
    end else if (cycle_end) begin
      wel_r <= 1'b0;
    end else if (cs_rise && set_pend_r) begin
      wel_r <= 1'b1;
    end else if (cmd_end && rx_byte == OP_LATCH_CLEAR && !busy_r) begin
      wel_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Status register write
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sr_new_r <= 8'h00;
      sr_got_r <= 1'b0;
      sr_ok_r  <= 1'b0;
    end else if (cmd_end) begin
      sr_got_r <= 1'b0;
      sr_ok_r  <= 1'b1;
    end else if (st_r == ST_SRW) begin
      if (wp_block) begin
        sr_ok_r <= 1'b0;
      end
      if (byte_end) begin
        sr_new_r <= rx_byte;
        sr_got_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      gate_r <= GATE_RESET;
      bg_r   <= BG_RESET;
    end else if (sr_go) begin
      gate_r <= sr_new_r[SR_GATE_POS];
      bg_r   <= {sr_new_r[SR_BG_HI_POS], sr_new_r[SR_BG_LO_POS]};
    end
  end

  // ----------------------------------------------------------------
  // Page buffer
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      vld_r <= '0;
      for (int i = 0; i < PAGE_BYTES; i++) begin
        page_r[i] <= 8'h00;
      end
    end else if (cycle_end || (cmd_end && !busy_r)) begin
      vld_r <= '0;
    end else if (wbyte_end) begin
      page_r[addr_r[PAGE_W-1:0]] <= rx_byte;
      if (!guarded(bg_r, addr_r)) begin
        vld_r[addr_r[PAGE_W-1:0]] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Internal write cycle
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      busy_r   <= 1'b0;
      wc_cnt_r <= '0;
      cm_idx_r <= '0;
    end else if (!busy_r) begin
      if (wr_go || sr_go) begin
        busy_r   <= 1'b1;
        wc_cnt_r <= '0;
        cm_idx_r <= wr_go ? '0 : (PAGE_W + 1)'(PAGE_BYTES);
      end
    end else begin
      wc_cnt_r <= wc_cnt_r + WC_CNT_W'(1);
      if (!cm_idx_r[PAGE_W]) begin
        cm_idx_r <= cm_idx_r + (PAGE_W + 1)'(1);
      end
      if (cycle_end) begin
        busy_r <= 1'b0;
      end
    end
  end

  assign arr.wr_en   = busy_r && !cm_idx_r[PAGE_W] && vld_r[cm_idx_r[PAGE_W-1:0]];
  assign arr.wr_addr = {addr_r[ADDR_W-1:PAGE_W], cm_idx_r[PAGE_W-1:0]};
  assign arr.wr_data = page_r[cm_idx_r[PAGE_W-1:0]];
  assign arr.rd_addr = addr_r;

  // ----------------------------------------------------------------
  // Status output
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_busy <= 1'b0;
    end else begin
      o_busy <= busy_r;
    end
  end

endmodule // spi_eeprom

`default_nettype wire

// *** dv/spi_eeprom_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_properties #(
  parameter int unsigned P_WC_CYCLES = 200
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Pins
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_si,
  input wire logic i_hold_n,
  input wire logic i_wp_n,
  input wire logic o_so,
  input wire logic o_so_oe,
  input wire logic o_busy
);
  // ----
  // Helper counters
  // ----
  logic [5:0]  cs_hi_r;
  logic [3:0]  age_r;
  logic        sck_r;
  logic [31:0] busy_cnt_r;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cs_hi_r    <= 6'h00;
      age_r      <= 4'hF;
      sck_r      <= 1'b0;
      busy_cnt_r <= 32'h0;
    end else begin
      cs_hi_r    <= !i_cs_n ? 6'h00 : (cs_hi_r == 6'h3F) ? cs_hi_r : cs_hi_r + 6'h01;
      sck_r      <= i_sck;
      age_r      <= (sck_r && !i_sck) ? 4'h0 : (age_r == 4'hF) ? age_r : age_r + 4'h1;
      busy_cnt_r <= o_busy ? busy_cnt_r + 32'h1 : 32'h0;
    end
  end
  // ----
  // Properties
  // ----
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  reset_idle_a: assert property ($rose(i_nrst) |-> !o_busy && !o_so_oe)
    else $error("outputs active after reset");
  sel_float_a: assert property (i_cs_n [*6] |-> !o_so_oe)
    else $error("so driven while deselected");
  hold_float_a: assert property (!i_hold_n [*6] |-> !o_so_oe)
    else $error("so driven during pause");
  hold_freeze_a: assert property (!i_hold_n [*6] |=> $stable(o_so))
    else $error("so moved during pause");
  so_edge_a: assert property (o_so_oe && $past(o_so_oe) && (o_so != $past(o_so)) |-> age_r <= 4'h8)
    else $error("so changed away from a falling edge");
  oe_sel_a: assert property ($rose(o_so_oe) |-> !i_cs_n && i_hold_n)
    else $error("so enabled outside a session");
  busy_start_a: assert property ($rose(o_busy) |-> cs_hi_r inside {[6'h02:6'h0C]})
    else $error("busy rose without select rising");
  busy_len_a: assert property ($fell(o_busy) |-> busy_cnt_r >= P_WC_CYCLES - 2 && busy_cnt_r <= P_WC_CYCLES + 2)
    else $error("write cycle length wrong");
  busy_max_a: assert property (o_busy |-> busy_cnt_r <= P_WC_CYCLES + 2)
    else $error("busy held too long");
  busy_c: cover property ($rose(o_busy));
  hold_c: cover property (!i_hold_n && !i_cs_n && !o_so_oe);
  read_c: cover property ($rose(o_so_oe));
endmodule // spi_eeprom_properties

bind spi_eeprom spi_eeprom_properties #(.P_WC_CYCLES(P_WC_CYCLES)) props_u (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_sck(i_sck), .i_cs_n(i_cs_n), .i_si(i_si),
  .i_hold_n(i_hold_n), .i_wp_n(i_wp_n), .o_so(o_so), .o_so_oe(o_so_oe), .o_busy(o_busy));
`default_nettype wire

// *** dv/spi_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module spi_host (
  // Clock
  input  wire logic i_clk,
  // Link pins
  output var  logic o_sck,
  output var  logic o_cs_n,
  output var  logic o_si,
  output var  logic o_hold_n,
  input  wire logic i_so,
  input  wire logic i_so_oe
);
  // ----
  // Frame engine
  // ----
  wire logic  so_w = i_so_oe ? i_so : 1'bz;
  logic [7:0] rx[$];
  logic       oe_seen;
  logic       hold_oe;
  logic       cpol;

  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
    o_hold_n = 1'b1;
    cpol = 1'b0;
  end

  task automatic half();
    repeat (16) @(posedge i_clk);
    #1;
  endtask

  task automatic frame(input logic [7:0] tx[$], input int nrd, input int hold_at);
    logic [7:0] b;
    int         i;
    int         k;
    rx = {};
    oe_seen = 1'b0;
    hold_oe = 1'b0;
    o_sck = cpol;
    half();
    o_cs_n = 1'b0;
    half();
    for (i = 0; i < tx.size() + nrd; i++) begin
      if (i == hold_at) begin
        o_sck = 1'b0;
        half();
        o_hold_n = 1'b0;
        half();
        o_si = ~o_si;
        o_sck = 1'b1;
        half();
        o_sck = 1'b0;
        hold_oe = (i_so_oe === 1'b1);
        half();
        o_hold_n = 1'b1;
        half();
      end
      b = (i < tx.size()) ? tx[i] : 8'(i * 37);
      for (k = 7; k >= 0; k--) begin
        o_sck = 1'b0;
        o_si = b[k];
        half();
        b[k] = so_w;
        oe_seen = oe_seen | (i_so_oe === 1'b1);
        o_sck = 1'b1;
        half();
      end
      if (i >= tx.size()) rx.push_back(b);
    end
    o_sck = cpol;
    half();
    o_cs_n = 1'b1;
    o_si = ~o_si;
    half();
  endtask
endmodule // spi_host
`default_nettype wire

// *** dv/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import eeprom_pkg::*;
  localparam int unsigned WC = 1200;
  // ----
  // Signals and model
  // ----
  logic i_clk, i_nrst, i_wp_n, sck, cs_n, si, hold_n, o_so, o_so_oe, o_busy;
  int   n_mismatch, n_tests, seed, gate, bg, latch, bsy, i, g;
  int   mem [DEPTH];

  spi_eeprom #(.P_WC_CYCLES(WC)) dut_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_sck(sck),
    .i_cs_n(cs_n), .i_si(si), .i_hold_n(hold_n), .i_wp_n(i_wp_n), .o_so(o_so),
    .o_so_oe(o_so_oe), .o_busy(o_busy));
  spi_host host_u (.i_clk(i_clk), .o_sck(sck), .o_cs_n(cs_n), .o_si(si), .o_hold_n(hold_n),
    .i_so(o_so), .i_so_oe(o_so_oe));

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  function automatic bit guard(input int p);
    return bg == 3 || (bg == 2 && p >= 512) || (bg == 1 && p >= 768);
  endfunction

  task automatic op(input logic [7:0] c);
    host_u.frame({c}, 0, -1);
  endtask

  task automatic wen();
    op(OP_LATCH_SET);
    latch = 1;
  endtask

  task automatic rs();
    host_u.frame({OP_SR_READ}, 1, -1);
    check("status", 32'(host_u.rx[0]), bsy ? 32'hFF : 32'((gate << 7) | (bg << 2) | (latch << 1)));
  endtask

  task automatic rd(input int a, input int n, input int h);
    int k;
    host_u.frame({OP_ARRAY_READ, 8'(a >> 8), 8'(a)}, n, h);
    for (k = 0; k < n; k++)
      if (mem[(a + k) % DEPTH] >= 0) check("array", 32'(host_u.rx[k]), mem[(a + k) % DEPTH]);
  endtask

  task automatic wr(input int a, input int n);
    logic [7:0]  q[$];
    logic [15:0] ad;
    int          p, k;
    ad = 16'(a) | 16'($random(seed) << 10);
    q = {OP_ARRAY_WRITE, ad[15:8], ad[7:0]};
    for (k = 0; k < n; k++) begin
      q.push_back(8'($random(seed)));
      p = (a & 32'h3E0) | ((a + k) & 31);
      if (latch == 1 && !guard(p)) mem[p] = q[k + 3];
    end
    host_u.frame(q, 0, -1);
  endtask

  task automatic settle(input int exp, input bit probe);
    int k;
    k = 0;
    while (o_busy !== 1'b1 && k < 20) begin
      tick(1);
      k++;
    end
    if (exp != 2) check("busy start", 32'(o_busy), exp);
    if (o_busy === 1'b1) latch = 0;
    bsy = (o_busy === 1'b1);
    if (probe) begin
      rs();
      op(OP_LATCH_SET);
      check("busy", 32'(o_busy), 1);
    end
    k = 0;
    while (o_busy === 1'b1 && k < WC + 50) begin
      tick(1);
      k++;
    end
    if (k >= WC + 50) begin
      n_mismatch++;
      test_done();
    end
    bsy = 0;
  endtask

  task automatic sw(input logic [7:0] v, input bit drop);
    int ok;
    ok = latch == 1 && !drop && !(gate == 1 && i_wp_n == 1'b0);
    fork
      host_u.frame({OP_SR_WRITE, v}, 0, -1);
      if (drop) begin
        tick(300);
        i_wp_n = 1'b0;
      end
    join
    if (ok) begin
      gate = v[7];
      bg = v[3:2];
    end
    settle(ok ? 1 : 0, 0);
    if (!ok) begin
      op(OP_LATCH_CLEAR);
      latch = 0;
    end
  endtask

  // ----
  // Scenarios
  // ----
  initial begin
    seed = 32'h314D;
    n_mismatch = 0;
    n_tests = 0;
    gate = 0;
    bg = 0;
    latch = 0;
    bsy = 0;
    i_nrst = 1'b0;
    i_wp_n = 1'b1;
    foreach (mem[i]) mem[i] = -1;
    repeat (8) @(posedge i_clk);
    #1 i_nrst = 1'b1;
    tick(4);
    check("busy", 32'(o_busy), 0);
    rs();
    wen();
    rs();
    op(OP_LATCH_CLEAR);
    latch = 0;
    rs();
    host_u.frame({OP_LATCH_SET, 8'h00}, 0, -1);
    rs();
    wr(32'h01E, 2);
    settle(0, 0);
    wen();
    wr(32'h01E, 34);
    settle(1, 1);
    rs();
    rd(0, 32, 5);
    check("hold float", 32'(host_u.hold_oe), 0);
    wen();
    wr(32'h3F0, 32);
    settle(1, 0);
    rd(32'h3FE, 4, -1);
    for (g = 0; g < 4; g++) begin
      wen();
      sw(8'(($random(seed) & 32'h73) | (g << 2)), 0);
      rs();
      for (i = 1; i < 4; i++) begin
        wen();
        wr(i * 256 + 255, 1);
        settle(guard(i * 256 + 255) ? 0 : 1, 0);
        rd(i * 256 + 255, 1, -1);
      end
    end
    wen();
    sw(8'h80, 0);
    i_wp_n = 1'b0;
    wen();
    sw(8'h0C, 0);
    rs();
    i_wp_n = 1'b1;
    wen();
    sw(8'h0C, 1);
    rs();
    i_wp_n = 1'b1;
    wen();
    sw(8'h08, 0);
    i_wp_n = 1'b0;
    wen();
    sw(8'h04, 0);
    rs();
    i_wp_n = 1'b1;
    host_u.frame({8'hA5, 8'h00, 8'h00}, 2, -1);
    check("unknown oe", 32'(host_u.oe_seen), 0);
    host_u.cpol = 1'b1;
    wen();
    rs();
    rd(32'h3FE, 4, -1);
    host_u.cpol = 1'b0;
    test_done();
  end
endmodule // testbench
`default_nettype wire
